// ===== shared/usif_defs.svh
/*
 * Offsets, field positions, reset values and counts for the serial status
 * and interrupt flag block.
 * Assumes byte addressing on a 32-bit APB with one aligned word a register.
 */
`ifndef USIF_DEFS_SVH
`define USIF_DEFS_SVH

// Register byte offsets.
`define USIF_OFS_STATUS 8'h00
`define USIF_OFS_ICTRL 8'h04
`define USIF_OFS_RXHOLD 8'h08
`define USIF_OFS_TXHOLD 8'h0c
`define USIF_OFS_EVSTAT 8'h10
`define USIF_OFS_EVMASK 8'h14

// Status register bits.
`define USIF_ST_PE 0
`define USIF_ST_FE 1
`define USIF_ST_OE 2
`define USIF_ST_ERR 3
`define USIF_ST_BRK 4

// Interrupt control register bits.
`define USIF_IC_TBE 0
`define USIF_IC_RBF 1
`define USIF_IC_DCTS 2
`define USIF_IC_CTS 3
`define USIF_IC_EFCI 4
`define USIF_IC_ETI 5
`define USIF_IC_ERI 6
`define USIF_IC_EEI 7
`define USIF_IC_RESET 8'h01

// Event status and mask bits.
`define USIF_EV_TBE 0
`define USIF_EV_RBF 1
`define USIF_EV_ERR 2
`define USIF_EV_CTS 3
`define USIF_EV_BRK 4
`define USIF_EV_W 5

// Bit times the line must stay low to count as a break.
`define USIF_BREAK_BITS 4'd10

`endif

// ===== shared/usif_pkg.sv
/*
 * Types for the serial status and interrupt flag block.
 * Assumes usif_defs.svh supplies the numeric constants.
 */
package usif_pkg;

  // One received frame as handed over by the receive shifter.
  typedef struct packed {
    logic valid;
    logic parity_bad;
    logic stop_bad;
    logic [7:0] data;
  } usif_rx_frame_t;

  // Break detector states, Gray coded along idle, armed, break.
  typedef enum logic [1:0] {
    USIF_BRK_IDLE = 2'b00,
    USIF_BRK_ARMED = 2'b01,
    USIF_BRK_HELD = 2'b11
  } usif_brk_state_t;

endpackage

// ===== src/usif_core.sv
/*
 * Status and interrupt flag logic of an asynchronous serial port, with an
 * APB slave for its registers and one level interrupt output.
 * Assumes a receive shifter that hands over whole frames with their error
 * marks, a transmit shifter that pulses when it takes the held byte, and a
 * one-cycle pulse for each bit time. All inputs are synchronous to pclk.
 *
// Overview of operation
// - Parity error flag sets on bad parity, clears on status read.
// - Framing error flag sets on missing stop bit, clears on status read.
// - Overrun flag sets when a frame lands on unread data; status read clears.
// - Summary error flag is set while any of parity, framing, overrun is set.
// - Summary error flag clears by itself once all three are zero.
// - Break flag sets when line stays low ten bit times after framing error.
// - Status read clears break only if line is high; line high clears it.
// - Transmit-empty flag sets when held byte moves to shifter; 1 is empty.
// - Transmit-empty flag clears on next write of transmit holding register.
// - Receive-full flag sets when a whole frame lands in the holding register.
// - Receive-full flag clears when software reads receive holding; 1 loaded.
// - CTS change flag sets on input change, clears on interrupt control read.
// - CTS level flag reads 1 when input is low, 0 when high.
// - Interrupt control flag bits are read-only; only enable bits take writes.
// - Interrupt control register resets to 01h.
// - Enables let hardware setting of their flag raise an interrupt.
// - Status register is read-only; writes are ignored.
 */
`timescale 1ns/100ps
`include "usif_defs.svh"

module usif_core
  import usif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire usif_rx_frame_t rx_frame,
  input wire logic rx_line,
  input wire logic bit_tick,
  input wire logic cts_n,
  input wire logic tx_take,
  output logic [7:0] tx_data,
  output logic tx_loaded,
  output logic irq
);

  // Sticky update where a set in the same cycle wins over the clear.
  function automatic logic [4:0] sticky(input logic [4:0] cur,
                                        input logic [4:0] set,
                                        input logic [4:0] clr);
    sticky = set | (cur & ~clr);
  endfunction

  // A completed access to one register offset. Decoding through one
  // function keeps every register strobe qualified the same way.
  function automatic logic hits(input logic strobe,
                                input logic [7:0] a,
                                input logic [7:0] ofs);
    hits = strobe & (a == ofs);
  endfunction

  // True when the next bit time completes the break length. The sum stays
  // four bits wide, which holds since the count never passes the limit.
  function automatic logic brk_reached(input logic [3:0] cnt);
    brk_reached = (4'(cnt + 4'h1) >= `USIF_BREAK_BITS);
  endfunction

  logic setup;
  logic done;
  logic rd_done;
  logic wr_done;
  logic [7:0] addr_q;
  logic [7:0] cap_q;
  logic pe_q;
  logic fe_q;
  logic oe_q;
  logic brk_q;
  logic [7:0] rx_hold_q;
  logic rbf_q;
  logic tbe_q;
  logic [7:0] tx_hold_q;
  logic cts_prev_q;
  logic dcts_q;
  logic [2:0] en_q;
  logic efci_q;
  logic [4:0] ev_q;
  logic [4:0] mask_q;
  logic [3:0] brk_cnt_q;
  usif_brk_state_t brk_st_q;
  logic [7:0] status_v;
  logic [7:0] ictrl_v;
  logic rd_status;
  logic rd_ictrl;
  logic rx_take;
  logic [4:0] ev_set;
  logic mapped;
  logic tx_wr;
  logic brk_hit;
  logic [4:0] ev_clr;
  logic [4:0] ev_d;
  logic [4:0] mask_d;

  //////////////////////////////////////////////////////////////////////////
  // APB slave.

  // Read data is captured in the setup cycle, so pready rises in the first
  // access cycle and no wait state is added. Capturing at setup also tells
  // the read-clear flags exactly which bits software was shown.
  assign setup = psel & ~penable;
  assign done = psel & penable & pready;
  assign rd_done = done & ~pwrite;
  assign wr_done = done & pwrite & ~pslverr;
  assign rd_status = hits(rd_done, addr_q, `USIF_OFS_STATUS);
  assign rd_ictrl = hits(rd_done, addr_q, `USIF_OFS_ICTRL);
  // The transmit holding write is used by several processes below.
  assign tx_wr = hits(wr_done, addr_q, `USIF_OFS_TXHOLD);
  assign mapped = (paddr == `USIF_OFS_STATUS) | (paddr == `USIF_OFS_ICTRL) |
                  (paddr == `USIF_OFS_RXHOLD) | (paddr == `USIF_OFS_TXHOLD) |
                  (paddr == `USIF_OFS_EVSTAT) | (paddr == `USIF_OFS_EVMASK);

  // Summary bit follows the three error flags combinationally.
  assign status_v = {3'h0, brk_q, pe_q | fe_q | oe_q, oe_q, fe_q, pe_q};
  // CTS level reads inverted from the active-low pin.
  assign ictrl_v = {en_q, efci_q, ~cts_n, dcts_q, rbf_q, tbe_q};

  // Answer flops for the access phase.
  // Unmapped offsets answer with an error and zero data; writes there are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      addr_q <= 8'h00;
      cap_q <= 8'h00;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      addr_q <= paddr;
      prdata <= 32'h0;
      cap_q <= 8'h00;
      if (!pwrite) begin
        case (paddr)
          `USIF_OFS_STATUS: begin
            prdata <= {24'h0, status_v};
            cap_q <= status_v;
          end
          `USIF_OFS_ICTRL: begin
            prdata <= {24'h0, ictrl_v};
            cap_q <= ictrl_v;
          end
          `USIF_OFS_RXHOLD: prdata <= {24'h0, rx_hold_q};
          `USIF_OFS_TXHOLD: prdata <= {24'h0, tx_hold_q};
          `USIF_OFS_EVSTAT: prdata <= {27'h0, ev_q};
          `USIF_OFS_EVMASK: prdata <= {27'h0, mask_q};
          default: prdata <= 32'h0;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive side.

  // A frame counts only in the cycle its valid mark is high.
  assign rx_take = rx_frame.valid;

  // Holding register and full flag; a landing frame wins over a read.
  // Losing that read's clear is harmless, as the new byte is unread anyway.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold_q <= 8'h00;
      rbf_q <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_hold_q <= rx_frame.data;
        rbf_q <= 1'b1;
      end else if (hits(rd_done, addr_q, `USIF_OFS_RXHOLD)) begin
        rbf_q <= 1'b0;
      end
    end
  end

  // Error flags latch with the frame. Only bits the read actually saw are
  // cleared, so an error landing between setup and access is kept.
  // Overrun looks at the full flag as it stood before this frame landed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      pe_q <= (rx_take & rx_frame.parity_bad) |
              (pe_q & ~(rd_status & cap_q[`USIF_ST_PE]));
      fe_q <= (rx_take & rx_frame.stop_bad) |
              (fe_q & ~(rd_status & cap_q[`USIF_ST_FE]));
      oe_q <= (rx_take & rbf_q) |
              (oe_q & ~(rd_status & cap_q[`USIF_ST_OE]));
    end
  end

  // The bit time that completes a break while the detector is armed.
  // Both the flag and its event take this one term, so they cannot drift.
  assign brk_hit = (brk_st_q == USIF_BRK_ARMED) & bit_tick & ~rx_line &
                   brk_reached(brk_cnt_q);

  // Break detector: armed by a framing error, counts low bit times.
  // Limitation: a frame whose stop bit fails on a high line does not arm
  // it, since the line must already be low when the frame lands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_st_q <= USIF_BRK_IDLE;
      brk_cnt_q <= 4'h0;
    end else begin
      case (brk_st_q)
        USIF_BRK_IDLE: begin
          brk_cnt_q <= 4'h0;
          if (rx_take && rx_frame.stop_bad && !rx_line) begin
            brk_st_q <= USIF_BRK_ARMED;
          end
        end
        USIF_BRK_ARMED: begin
          if (rx_line) begin
            brk_st_q <= USIF_BRK_IDLE;
          end else if (bit_tick) begin
            brk_cnt_q <= brk_cnt_q + 4'h1;
            if (brk_reached(brk_cnt_q)) begin
              brk_st_q <= USIF_BRK_HELD;
            end
          end
        end
        USIF_BRK_HELD: begin
          if (rx_line) begin
            brk_st_q <= USIF_BRK_IDLE;
          end
        end
        default: brk_st_q <= USIF_BRK_IDLE;
      endcase
    end
  end

  // Break flag: set on the transition to held; a read clears it only once
  // the line is high, and the line going high also clears it by itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_q <= 1'b0;
    end else if (brk_hit) begin
      brk_q <= 1'b1;
    end else if (rx_line && brk_st_q == USIF_BRK_HELD) begin
      brk_q <= 1'b0;
    end else if (rd_status && cap_q[`USIF_ST_BRK] && rx_line) begin
      brk_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit side.

  // A write of new data wins over a take in the same cycle, since the
  // holding register is loaded again at that edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_q <= 8'h00;
      tbe_q <= 1'b1;
    end else if (tx_wr) begin
      tx_hold_q <= pwdata[7:0];
      tbe_q <= 1'b0;
    end else if (tx_take && !tbe_q) begin
      tbe_q <= 1'b1;
    end
  end

  // Shifter-facing copies, straight from flops.
  // Both are built from the next state of the holding register and its flag, so they never trail them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data <= 8'h00;
      tx_loaded <= 1'b0;
    end else begin
      tx_data <= tx_wr ? pwdata[7:0] : tx_hold_q;
      tx_loaded <= tx_wr | (~tbe_q & ~tx_take);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clear-to-send tracking.

  // Change flag; a change in the clearing read's cycle is kept.
  // The previous level resets high, the idle level of the pin, so no false
  // change follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_prev_q <= 1'b1;
      dcts_q <= 1'b0;
    end else begin
      cts_prev_q <= cts_n;
      dcts_q <= (cts_n ^ cts_prev_q) |
                (dcts_q & ~(rd_ictrl & cap_q[`USIF_IC_DCTS]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt control, event status and mask registers.

  // Only the enable bits take writes; flag positions ignore them.
  // The cts-change enable resets low together with the other enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 3'(`USIF_IC_RESET >> `USIF_IC_ETI);
      efci_q <= 1'b0;
      mask_q <= 5'h00;
    end else if (wr_done) begin
      if (addr_q == `USIF_OFS_ICTRL) begin
        en_q <= pwdata[`USIF_IC_EEI:`USIF_IC_ETI];
        efci_q <= pwdata[`USIF_IC_EFCI];
      end
      if (addr_q == `USIF_OFS_EVMASK) begin
        mask_q <= pwdata[4:0];
      end
    end
  end

  // Hardware setting of each flag, gated by its enable; the break event has no enable.
  // The cts event is taken only on the flag's rise, as a repeated change
  // while the flag is still set is not a new event.
  always_comb begin
    ev_set = 5'h00;
    ev_set[`USIF_EV_TBE] = en_q[0] & tx_take & ~tbe_q & ~tx_wr;
    ev_set[`USIF_EV_RBF] = en_q[1] & rx_take;
    ev_set[`USIF_EV_ERR] = en_q[2] & rx_take &
                           (rx_frame.parity_bad | rx_frame.stop_bad | rbf_q);
    ev_set[`USIF_EV_CTS] = efci_q & (cts_n ^ cts_prev_q) & ~dcts_q;
    ev_set[`USIF_EV_BRK] = ~brk_q & brk_hit;
  end

  // Next event status and mask. The interrupt flop takes these rather
  // than the registers, so it rises and falls in the same cycle as the
  // status it reports; a clear that lagged would give a spurious request.
  always_comb begin
    ev_clr = hits(wr_done, addr_q, `USIF_OFS_EVSTAT) ? pwdata[4:0] : 5'h00;
    ev_d = sticky(ev_q, ev_set, ev_clr);
    mask_d = hits(wr_done, addr_q, `USIF_OFS_EVMASK) ? pwdata[4:0] : mask_q;
  end

  // Event status is write-one-to-clear; status writes elsewhere are
  // dropped, which keeps the status register read-only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= 5'h00;
    end else begin
      ev_q <= ev_d;
    end
  end

  // Level interrupt, registered, high while an unmasked event is recorded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_d & mask_d);
    end
  end

endmodule

// ===== verif/usif_core_checker.sv
/*
 * Port checker for the serial status and interrupt flag block.
 * Assumes the bind at the foot of this file and the usif_defs.svh constants.
 */
`timescale 1ns/100ps
`include "usif_defs.svh"

module usif_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_take,
  input wire logic [7:0] tx_data,
  input wire logic tx_loaded,
  input wire logic irq
);
  // One clock domain, so the clock and the reset are stated once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // An access edge; the transmit write is named since three checks use it.
  wire logic acc = psel && penable && pready;
  wire logic txw = acc && pwrite && paddr == `USIF_OFS_TXHOLD;

  AST_SETUP_ANSWER:
    assert property (psel && !penable |=> pready) else $error("no answer after setup");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("ready held too long");
  AST_ERR_ZERO:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
  AST_UPPER_ZERO:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_MAPPED_OK:
    assert property (acc && paddr <= `USIF_OFS_EVMASK && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("error on mapped address");
  AST_TX_LOAD:
    assert property (txw |-> ##[1:2] tx_loaded) else $error("holding write not loaded");
  AST_TX_DATA:
    assert property (txw |=> {24'h0, tx_data} == ($past(pwdata) & 32'hff))
      else $error("held byte differs");
  AST_TX_TAKEN:
    assert property (tx_take && tx_loaded && !txw |-> ##[1:2] !tx_loaded)
      else $error("take did not empty holding");
  AST_MASK_OFF:
    assert property (acc && pwrite && paddr == `USIF_OFS_EVMASK && pwdata[4:0] == 5'h0
      |-> ##[1:2] !irq) else $error("irq with all masked");
endmodule

bind usif_core usif_core_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_take(tx_take), .tx_data(tx_data),
  .tx_loaded(tx_loaded), .irq(irq));

// ===== verif/usif_peer.sv
/*
 * Remote serial peer as the flag block sees it: frame hand-over, line level,
 * bit tick, clear-to-send and transmit take.
 * Assumes the bench calls its tasks right after a rising pclk edge.
 */
`timescale 1ns/100ps

module usif_peer
  import usif_pkg::*;
(
  input wire logic pclk,
  output usif_rx_frame_t rx_frame,
  output logic rx_line,
  output logic bit_tick,
  output logic cts_n,
  output logic tx_take
);
  logic [1:0] div_q = 2'b00;

  // A short bit time of four clocks keeps the break scenario brief.
  always_ff @(posedge pclk) begin
    div_q <= div_q + 2'b01;
  end
  assign bit_tick = (div_q == 2'b11);

  // Line idles high and clear-to-send starts deasserted.
  initial begin
    rx_frame = '0;
    rx_line = 1'b1;
    cts_n = 1'b1;
    tx_take = 1'b0;
  end

  // After its pulse the frame shows inverted content, so stale data is never reused.
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge pclk);
    rx_frame <= '{1'b1, p, s, d};
    @(posedge pclk);
    rx_frame <= '{1'b0, ~p, ~s, ~d};
  endtask

  task automatic take;
    @(posedge pclk);
    tx_take <= 1'b1;
    @(posedge pclk);
    tx_take <= 1'b0;
  endtask

  task automatic set_line(input logic v);
    @(posedge pclk);
    rx_line <= v;
  endtask

  task automatic set_cts(input logic v);
    @(posedge pclk);
    cts_n <= v;
  endtask
endmodule

// ===== verif/tb_usif_core.sv
/*
 * Self-checking bench for usif_core over APB with a remote peer model.
 * Assumes usif_peer.sv and the checker are compiled ahead of this file.
 */
`timescale 1ns/100ps
`include "usif_defs.svh"

module tb_usif_core
  import usif_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_loaded, irq, rx_line, bit_tick, cts_n, tx_take, er;
  logic [7:0] tx_data;
  logic [31:0] rd;
  usif_rx_frame_t rx_frame;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  // 20 MHz clock.
  initial forever #25 pclk = ~pclk;

  usif_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame(rx_frame), .rx_line(rx_line), .bit_tick(bit_tick),
    .cts_n(cts_n), .tx_take(tx_take), .tx_data(tx_data), .tx_loaded(tx_loaded), .irq(irq));

  usif_peer peer_u (.pclk(pclk), .rx_frame(rx_frame), .rx_line(rx_line),
    .bit_tick(bit_tick), .cts_n(cts_n), .tx_take(tx_take));

  ////////////////////////////////////////
  task automatic wrap_up;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The leading edge keeps a new setup from landing on the last release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // A hang is cut short here and counted as a mismatch.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  // Register, receive, break, transmit, clear-to-send and interrupt scenarios.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`USIF_OFS_ICTRL, 32'h01);
    apb(1'b1, `USIF_OFS_STATUS, 32'hff);
    rdc(`USIF_OFS_STATUS, 32'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    peer_u.send(8'ha5, 1'b1, 1'b0);
    rdc(`USIF_OFS_STATUS, 32'h09);
    rdc(`USIF_OFS_STATUS, 32'h00);
    rdc(`USIF_OFS_ICTRL, 32'h03);
    rdc(`USIF_OFS_RXHOLD, 32'ha5);
    rdc(`USIF_OFS_ICTRL, 32'h01);
    peer_u.send(8'h11, 1'b0, 1'b1);
    peer_u.send(8'h22, 1'b0, 1'b0);
    rdc(`USIF_OFS_STATUS, 32'h0e);
    rdc(`USIF_OFS_RXHOLD, 32'h22);
    peer_u.set_line(1'b0);
    peer_u.send(8'h00, 1'b0, 1'b1);
    repeat (24) @(posedge pclk);
    rdc(`USIF_OFS_STATUS, 32'h0a);
    repeat (32) @(posedge pclk);
    rdc(`USIF_OFS_STATUS, 32'h10);
    rdc(`USIF_OFS_STATUS, 32'h10);
    peer_u.set_line(1'b1);
    rdc(`USIF_OFS_STATUS, 32'h00);
    rdc(`USIF_OFS_RXHOLD, 32'h00);
    apb(1'b1, `USIF_OFS_TXHOLD, 32'h5a);
    rdc(`USIF_OFS_ICTRL, 32'h00);
    chk({24'h0, tx_data}, 32'h5a);
    peer_u.take();
    rdc(`USIF_OFS_ICTRL, 32'h01);
    peer_u.set_cts(1'b0);
    rdc(`USIF_OFS_ICTRL, 32'h0d);
    rdc(`USIF_OFS_ICTRL, 32'h09);
    apb(1'b1, `USIF_OFS_ICTRL, 32'hff);
    rdc(`USIF_OFS_ICTRL, 32'hf9);
    apb(1'b1, `USIF_OFS_EVSTAT, 32'h1f);
    apb(1'b1, `USIF_OFS_EVMASK, 32'h01);
    apb(1'b1, `USIF_OFS_TXHOLD, 32'h33);
    peer_u.take();
    rdc(`USIF_OFS_ICTRL, 32'hf9);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `USIF_OFS_EVSTAT, 32'h01);
    rdc(`USIF_OFS_EVSTAT, 32'h00);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `USIF_OFS_EVMASK, 32'h00);
    peer_u.send(8'h44, 1'b0, 1'b0);
    rdc(`USIF_OFS_RXHOLD, 32'h44);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `USIF_OFS_EVMASK, 32'h02);
    rdc(`USIF_OFS_EVSTAT, 32'h02);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `USIF_OFS_EVSTAT, 32'h1f);
    apb(1'b1, `USIF_OFS_EVMASK, 32'h1c);
    peer_u.set_cts(1'b1);
    peer_u.send(8'h55, 1'b1, 1'b0);
    rdc(`USIF_OFS_EVSTAT, 32'h0e);
    chk({31'h0, irq}, 32'h1);
    rdc(`USIF_OFS_ICTRL, 32'hf7);
    rdc(`USIF_OFS_STATUS, 32'h09);
    // A second reset in mid-run must bring the enables back to their reset value.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`USIF_OFS_ICTRL, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wrap_up();
  end
endmodule
